// ===== dpm_pkg.sv
// Package for the digital pin function multiplexer: selections, defaults and counts.
package dpm_pkg;
   localparam int NUM_PINS = 14;
   localparam int DRIVE_MA_STEP = 4;

   // Function kinds a pin can take; the selector does not use these codes.
   typedef enum logic [2:0] {
      DPM_FN_GPIO    = 3'b000,
      DPM_FN_SPECIAL = 3'b001,
      DPM_FN_ALT     = 3'b010,
      DPM_FN_BUS     = 3'b011
   } dpm_kind_e;

   // Pin 0 selection.
   localparam logic [1:0] P0_TX_ACTIVE = 2'h0;
   localparam logic [1:0] P0_TRANSMIT_LED    = 2'h1;
   localparam logic [1:0] P0_GPIO      = 2'h2;
   // Pin 7 selection.
   localparam logic [1:0] P7_SUSP_LOW  = 2'h0;
   localparam logic [1:0] P7_SUSP_HIGH = 2'h1;
   localparam logic [1:0] P7_PWREN_LOW = 2'h2;
   localparam logic [1:0] P7_GPIO      = 2'h3;
   // Pin 12 selection.
   localparam logic [1:0] P12_CHG_DET   = 2'h0;
   localparam logic [1:0] P12_RECEIVE_LED    = 2'h1;
   localparam logic [1:0] P12_PWREN_LOW = 2'h2;
   localparam logic [1:0] P12_GPIO      = 2'h3;

   // Interface configuration: bit pattern with only the I2C interface enabled.
   localparam logic [1:0] CFG_I2C_ONLY = 2'h1;

   // Reset values of pin outputs, directions, selections and drive strength.
   localparam logic [13:0] GPIO_OUT_RST = 14'h0000;
   localparam logic [13:0] GPIO_OE_RST  = 14'h0000;
   localparam logic [1:0]  SEL_RST      = 2'h3;
   localparam logic [1:0]  DRIVE_RST    = 2'h0;
endpackage

// ===== dpm_pin_cell.sv
// One digital pin: glitch-free registered output and enable from a chosen source.
`timescale 1ns/1ps
module dpm_pin_cell (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic arst_n,
   // Function sources
   input  wire logic func_out,
   input  wire logic func_oe,
   // Pad
   output logic      pad_out,
   output logic      pad_oe
);
   import dpm_pkg::*;

   // Registering the mux result removes decode hazards when the selection changes.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pad_out <= 1'b0;
         pad_oe  <= 1'b0;
      end else begin
         pad_out <= func_out; // R16
         pad_oe  <= func_oe;
      end
   end
endmodule

// ===== dpm_pin_mux.sv
// Function multiplexer for fourteen digital pins.
`timescale 1ns/1ps
// Contract
// R01: Fourteen pins, each bus or general function.
// R02: Pin 0 shows transmitter active while sending.
// R03: Pins 1,2,9,10,11,13 default general functions.
// R04: Pins 3,4 general only when UART disabled.
// R05: Pins 5,6 general only without I2C, EEPROM.
// R06: Pin 7 suspend low/high, power low, general.
// R07: Pin 8 wakeup input or general.
// R08: Pin 12 charger, receive LED, power, general.
// R09: Charger indicator active on dedicated charger.
// R10: Stored selections load at power-up first.
// R11: Drive strength four settings, 4 to 16 mA.
// R12: Host reads and drives general pins.
// R13: Power-on or external low reset clears all.
// R14: UART on: pin 3 receive, pin 4 transmit.
// R15: Pins 5,6 default to I2C clock, data.
// R16: Host change overrides default, no glitch.
module dpm_pin_mux (
   // Clock and reset
   input  wire logic                    sys_clk,
   input  wire logic                    arst_n,
   // Stored parameters and straps
   input  wire logic                    param_valid,
   input  wire logic [1:0]              param_sel_pin0,
   input  wire logic [1:0]              param_sel_pin7,
   input  wire logic [1:0]              param_sel_pin12,
   input  wire logic [1:0]              param_drive,
   input  wire logic                    eeprom_present,
   input  wire logic                    interface_config_bit0,
   input  wire logic                    interface_config_bit1,
   // Host requests over the control pipe
   input  wire logic                    host_sel_wr,
   input  wire logic [3:0]              host_sel_pin,
   input  wire logic [1:0]              host_sel_val,
   input  wire logic                    host_i2c_gpio,
   input  wire logic                    host_gpio_wr,
   input  wire logic [dpm_pkg::NUM_PINS-1:0] host_gpio_out,
   input  wire logic [dpm_pkg::NUM_PINS-1:0] host_gpio_oe,
   output logic [dpm_pkg::NUM_PINS-1:0] host_gpio_in,
   // Function engine signals
   input  wire logic                    uart_tx_busy,
   input  wire logic                    uart_txd,
   output logic                         uart_rxd,
   input  wire logic                    i2c_scl_oe,
   input  wire logic                    i2c_sda_oe,
   output logic                         i2c_scl_in,
   output logic                         i2c_sda_in,
   input  wire logic                    tx_activity,
   input  wire logic                    rx_activity,
   input  wire logic                    usb_suspended,
   input  wire logic                    charger_dedicated,
   output logic                         remote_wakeup,
   // Status
   output logic                         config_ready,
   output logic [4:0]                   drive_ma,
   // Pads
   input  wire logic [dpm_pkg::NUM_PINS-1:0] pad_in,
   output logic [dpm_pkg::NUM_PINS-1:0] pad_out,
   output logic [dpm_pkg::NUM_PINS-1:0] pad_oe
);
   import dpm_pkg::*;

   logic [1:0]          sel_pin0;
   logic [1:0]          sel_pin7;
   logic [1:0]          sel_pin12;
   logic                i2c_as_gpio;
   logic [1:0]          drive;
   logic [NUM_PINS-1:0] gpio_out;
   logic [NUM_PINS-1:0] gpio_oe;
   logic [NUM_PINS-1:0] func_out;
   logic [NUM_PINS-1:0] func_oe;
   logic                uart_on;
   logic                i2c_if_on;

   // Configuration 2'b01 is the only one without the UART interface.
   assign uart_on   = {interface_config_bit1, interface_config_bit0} != CFG_I2C_ONLY;
   assign i2c_if_on = {interface_config_bit1, interface_config_bit0} != 2'h2;

   // Parameters are taken once after reset; nothing drives until they are in.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin // R13
         config_ready <= 1'b0;
      end else if (param_valid) begin
         config_ready <= 1'b1; // R10
      end
   end

   // Selections: loaded defaults, then host overrides that stay until reset.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         sel_pin0  <= P0_GPIO;
         sel_pin7  <= SEL_RST;
         sel_pin12 <= SEL_RST;
         drive     <= DRIVE_RST;
      end else if (!config_ready) begin
         if (param_valid) begin // R10
            sel_pin0  <= param_sel_pin0;
            sel_pin7  <= param_sel_pin7;
            sel_pin12 <= param_sel_pin12;
            drive     <= param_drive; // R11
         end
      end else if (host_sel_wr) begin // R16
         unique case (host_sel_pin)
            4'h0:    sel_pin0  <= host_sel_val;
            4'h7:    sel_pin7  <= host_sel_val;
            4'hC:    sel_pin12 <= host_sel_val;
            default: sel_pin0  <= sel_pin0;
         endcase
      end
   end

   // Pins 5 and 6 leave the I2C bus only when allowed.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         i2c_as_gpio <= 1'b0; // R15
      end else if (config_ready && host_sel_wr && host_sel_pin == 4'h5) begin
         i2c_as_gpio <= host_i2c_gpio && !i2c_if_on && !eeprom_present; // R05
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         gpio_out <= GPIO_OUT_RST;
         gpio_oe  <= GPIO_OE_RST;
      end else if (host_gpio_wr) begin
         gpio_out <= host_gpio_out; // R12
         gpio_oe  <= host_gpio_oe;
      end
   end

   assign drive_ma = 5'(DRIVE_MA_STEP) * ({3'h0, drive} + 5'h01); // R11

   always_comb begin
      func_out = gpio_out; // R03
      func_oe  = gpio_oe & {NUM_PINS{config_ready}};
      unique case (sel_pin0)
         P0_TX_ACTIVE: begin
            func_out[0] = uart_tx_busy; // R02
            func_oe[0]  = config_ready;
         end
         P0_TRANSMIT_LED: begin
            func_out[0] = !tx_activity;
            func_oe[0]  = config_ready;
         end
         default: ;
      endcase
      if (uart_on) begin // R04
         func_out[3] = 1'b0; // R14
         func_oe[3]  = 1'b0;
         func_out[4] = uart_txd;
         func_oe[4]  = config_ready;
      end
      if (!i2c_as_gpio) begin
         // The bus engine may hold its enables before parameters load; keep the pads quiet.
         func_out[5] = 1'b0; // R15
         func_oe[5]  = i2c_scl_oe & config_ready;
         func_out[6] = 1'b0;
         func_oe[6]  = i2c_sda_oe & config_ready;
      end
      unique case (sel_pin7) // R06
         P7_SUSP_LOW:  begin func_out[7] = !usb_suspended; func_oe[7] = config_ready; end
         P7_SUSP_HIGH: begin func_out[7] = usb_suspended;  func_oe[7] = config_ready; end
         P7_PWREN_LOW: begin func_out[7] = usb_suspended;  func_oe[7] = config_ready; end
         P7_GPIO:      ;
      endcase
      if (sel_pin7 != P7_GPIO && !config_ready) begin
         func_oe[7] = 1'b0;
      end
      unique case (sel_pin12) // R08 R09
         P12_CHG_DET:   begin func_out[12] = charger_dedicated; func_oe[12] = config_ready; end
         P12_RECEIVE_LED:    begin func_out[12] = !rx_activity;      func_oe[12] = config_ready; end
         P12_PWREN_LOW: begin func_out[12] = usb_suspended;     func_oe[12] = config_ready; end
         P12_GPIO:      ;
      endcase
      // Pin 8 with the wakeup role is input only; the general role keeps host control.
      if (!gpio_oe[8]) begin // R07
         func_out[8] = 1'b0;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin // R01
         dpm_pin_cell u_cell (
            .sys_clk  (sys_clk),
            .arst_n   (arst_n),
            .func_out (func_out[gi]),
            .func_oe  (func_oe[gi]),
            .pad_out  (pad_out[gi]),
            .pad_oe   (pad_oe[gi])
         );
      end
   endgenerate

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         host_gpio_in  <= GPIO_OUT_RST;
         uart_rxd      <= 1'b1;
         i2c_scl_in    <= 1'b1;
         i2c_sda_in    <= 1'b1;
         remote_wakeup <= 1'b0;
      end else begin
         host_gpio_in  <= pad_in; // R12
         uart_rxd      <= uart_on ? pad_in[3] : 1'b1; // R14
         i2c_scl_in    <= i2c_as_gpio ? 1'b1 : pad_in[5];
         i2c_sda_in    <= i2c_as_gpio ? 1'b1 : pad_in[6];
         remote_wakeup <= !gpio_oe[8] && !pad_in[8] && config_ready; // R07
      end
   end

   AST_TXACT: assert property (@(posedge sys_clk) disable iff (!arst_n) // R02
      (config_ready && sel_pin0 == P0_TX_ACTIVE) |=> pad_out[0] == $past(uart_tx_busy))
      else $error("pin 0 does not follow transmitter activity");
   AST_CHG: assert property (@(posedge sys_clk) disable iff (!arst_n) // R09
      (config_ready && sel_pin12 == P12_CHG_DET) |=> pad_oe[12] && pad_out[12] == $past(charger_dedicated))
      else $error("charger indicator wrong");
   AST_UART: assert property (@(posedge sys_clk) disable iff (!arst_n) // R14
      (config_ready && uart_on) |=> !pad_oe[3] && pad_out[4] == $past(uart_txd))
      else $error("uart pins wrong");
   AST_I2C: assert property (@(posedge sys_clk) disable iff (!arst_n) // R05
      (i2c_if_on || eeprom_present) |-> !i2c_as_gpio || $stable(i2c_as_gpio))
      else $error("i2c pins released while in use");
   AST_NODRV: assert property (@(posedge sys_clk) disable iff (!arst_n) // R10
      !config_ready |=> pad_oe == 14'h0000)
      else $error("pin driven before parameters load");
   AST_GPIO: assert property (@(posedge sys_clk) disable iff (!arst_n) // R12
      (config_ready && host_gpio_wr) |=> ##1 pad_out[13] == $past(host_gpio_out[13], 2))
      else $error("general pin not applied");
   AST_DRIVE: assert property (@(posedge sys_clk) disable iff (!arst_n) // R11
      drive_ma >= 5'h04 && drive_ma <= 5'h10)
      else $error("drive strength out of range");
   AST_DRVLOAD: assert property (@(posedge sys_clk) disable iff (!arst_n) // R11
      $rose(config_ready) |-> drive_ma == {1'b0, $past(param_drive), 2'b00} + 5'h04)
      else $error("drive strength not loaded");
   AST_SUSP: assert property (@(posedge sys_clk) disable iff (!arst_n) // R06
      (config_ready && sel_pin7 == P7_SUSP_LOW) |=> pad_out[7] == !$past(usb_suspended))
      else $error("suspend indicator wrong");
endmodule

// ===== dpm_far_side.sv
// Board model on the digital pins: pull-ups and external drivers.
`timescale 1ns/1ps
module dpm_far_side
   import dpm_pkg::*;
(
   // Device side of the pads
   input  wire logic [NUM_PINS-1:0] pad_out,
   input  wire logic [NUM_PINS-1:0] pad_oe,
   // External drivers on the board
   input  wire logic [NUM_PINS-1:0] ext_oe,
   input  wire logic [NUM_PINS-1:0] ext_val,
   // Resolved pin levels
   output logic      [NUM_PINS-1:0] pad_in
);
   // Every pin has a board pull-up, so a released pin reads high rather than a stale level.
   // The open-drain bus pins rely on this pull-up for their high level.
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_oe & ext_val) | (~pad_oe & ~ext_oe);
endmodule

// ===== test_dpm_pin_mux.sv
// Self-checking bench for the digital pin function multiplexer.
`timescale 1ns/1ps
module test_dpm_pin_mux;
   import dpm_pkg::*;
   localparam logic [13:0] GP_MASK = 14'h2E1E;
   logic sys_clk, arst_n, param_valid, eeprom_present, interface_config_bit0;
   logic interface_config_bit1, host_sel_wr, host_i2c_gpio, host_gpio_wr, uart_tx_busy;
   logic uart_txd, uart_rxd, i2c_scl_oe, i2c_sda_oe, i2c_scl_in, i2c_sda_in, tx_activity;
   logic rx_activity, usb_suspended, charger_dedicated, remote_wakeup, config_ready;
   logic [1:0]  param_sel_pin0, param_sel_pin7, param_sel_pin12, param_drive, host_sel_val;
   logic [3:0]  host_sel_pin;
   logic [4:0]  drive_ma;
   logic [13:0] host_gpio_out, host_gpio_oe, host_gpio_in, pad_in, pad_out, pad_oe;
   logic [13:0] ext_oe, ext_val;
   int          err_count, checks_done;

   dpm_pin_mux dut (.*);
   dpm_far_side board (.*);

   always #2 sys_clk = ~sys_clk;

   task automatic chk(input string name, input logic [13:0] seen, input logic [13:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Outputs land two edges after a request; one more edge covers the input sample.
   task automatic look;
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask

   task automatic boot(input logic [1:0] cfg, drv, p0, p7, p12);
      @(posedge sys_clk);
      arst_n <= 1'b0;
      param_valid <= 1'b0;
      {interface_config_bit1, interface_config_bit0} <= cfg;
      {param_drive, param_sel_pin0, param_sel_pin7, param_sel_pin12} <= {drv, p0, p7, p12};
      repeat (6) @(negedge sys_clk);
      chk("reset_oe", pad_oe, 14'h0000);
      chk("reset_st", {9'h000, config_ready, uart_rxd, i2c_scl_in, i2c_sda_in, remote_wakeup},
          14'h000E);
      @(posedge sys_clk);
      arst_n <= 1'b1;
      @(posedge sys_clk);
      param_valid <= 1'b1;
      look;
   endtask

   task automatic host_sel(input logic [3:0] pin, input logic [1:0] val, input logic gp);
      @(posedge sys_clk);
      {host_sel_wr, host_sel_pin, host_sel_val, host_i2c_gpio} <= {1'b1, pin, val, gp};
      @(posedge sys_clk);
      host_sel_wr <= 1'b0;
      look;
   endtask

   task automatic host_gpio(input logic [13:0] val, input logic [13:0] oe);
      @(posedge sys_clk);
      {host_gpio_wr, host_gpio_out, host_gpio_oe} <= {1'b1, val, oe};
      @(posedge sys_clk);
      host_gpio_wr <= 1'b0;
      look;
   endtask

   task automatic t_load;
      for (int d = 0; d < 4; d++) begin
         boot(2'h1, 2'(d), P0_TX_ACTIVE, P7_SUSP_HIGH, P12_CHG_DET);
         chk("drive_ma", {9'h000, drive_ma}, 14'((d + 1) * DRIVE_MA_STEP));
         chk("ready", {13'h0000, config_ready}, 14'h0001);
      end
   endtask

   task automatic t_tx_active;
      @(posedge sys_clk);
      uart_tx_busy <= 1'b1;
      look;
      chk("txact_on", {12'h000, pad_oe[0], pad_out[0]}, 14'h0003);
      @(posedge sys_clk);
      uart_tx_busy <= 1'b0;
      look;
      chk("txact_off", {13'h0000, pad_out[0]}, 14'h0000);
      host_sel(4'h0, P0_TRANSMIT_LED, 1'b0);
      chk("txled_idle", {13'h0000, pad_out[0]}, 14'h0001);
      @(posedge sys_clk);
      tx_activity <= 1'b1;
      look;
      chk("txled_on", {13'h0000, pad_out[0]}, 14'h0000);
      @(posedge sys_clk);
      tx_activity <= 1'b0;
   endtask

   task automatic t_charger;
      @(posedge sys_clk);
      charger_dedicated <= 1'b1;
      look;
      chk("chg_on", {12'h000, pad_oe[12], pad_out[12]}, 14'h0003);
      @(posedge sys_clk);
      charger_dedicated <= 1'b0;
      look;
      chk("chg_off", {13'h0000, pad_out[12]}, 14'h0000);
   endtask

   task automatic t_suspend;
      @(posedge sys_clk);
      usb_suspended <= 1'b1;
      look;
      chk("susp_high", {13'h0000, pad_out[7]}, 14'h0001);
      host_sel(4'h7, P7_SUSP_LOW, 1'b0);
      chk("susp_low", {13'h0000, pad_out[7]}, 14'h0000);
      host_sel(4'hC, P12_PWREN_LOW, 1'b0);
      chk("pwr_off", {13'h0000, pad_out[12]}, 14'h0001);
      @(posedge sys_clk);
      usb_suspended <= 1'b0;
      look;
      chk("pwr_on", {12'h000, pad_out[12], pad_out[7]}, 14'h0001);
      host_sel(4'h7, P7_PWREN_LOW, 1'b0);
      host_sel(4'hC, P12_RECEIVE_LED, 1'b0);
      chk("pwr7_rx_idle", {12'h000, pad_out[12], pad_out[7]}, 14'h0002);
      @(posedge sys_clk);
      {rx_activity, usb_suspended} <= 2'b11;
      look;
      chk("pwr7_rx_busy", {12'h000, pad_out[12], pad_out[7]}, 14'h0001);
      @(posedge sys_clk);
      {rx_activity, usb_suspended} <= 2'b00;
   endtask

   task automatic t_gpio;
      host_gpio(14'h2A0A, GP_MASK);
      chk("gp_oe", pad_oe & GP_MASK, GP_MASK);
      chk("gp_out", pad_out & GP_MASK, 14'h2A0A & GP_MASK);
      chk("gp_in", host_gpio_in & GP_MASK, 14'h2A0A & GP_MASK);
      ext_oe <= GP_MASK;
      ext_val <= 14'h0414;
      host_gpio(14'h0000, 14'h0000);
      chk("gp_ext", host_gpio_in & GP_MASK, 14'h0414 & GP_MASK);
      ext_oe <= 14'h0000;
   endtask

   task automatic t_i2c;
      host_gpio(14'h0000, 14'h0060);
      @(posedge sys_clk);
      {i2c_sda_oe, i2c_scl_oe} <= 2'b11;
      look;
      chk("i2c_low", {10'h000, pad_oe[6:5], pad_out[6:5]}, 14'h000C);
      host_sel(4'h5, 2'h0, 1'b1);
      @(posedge sys_clk);
      {i2c_sda_oe, i2c_scl_oe} <= 2'b00;
      look;
      chk("i2c_rel", {10'h000, pad_oe[6:5], i2c_sda_in, i2c_scl_in}, 14'h0003);
   endtask

   task automatic t_uart;
      boot(2'h2, 2'h0, P0_GPIO, P7_GPIO, P12_GPIO);
      @(posedge sys_clk);
      uart_txd <= 1'b0;
      ext_oe[3] <= 1'b1;
      ext_val[3] <= 1'b0;
      look;
      chk("uart_lo", {11'h000, pad_oe[4], pad_out[4], uart_rxd}, 14'h0004);
      @(posedge sys_clk);
      uart_txd <= 1'b1;
      ext_val[3] <= 1'b1;
      look;
      chk("uart_hi", {12'h000, pad_out[4], uart_rxd}, 14'h0003);
      @(posedge sys_clk);
      eeprom_present <= 1'b1;
      host_gpio(14'h10E1, 14'h10E1);
      host_sel(4'h5, 2'h0, 1'b1);
      chk("i2c_eeprom", {12'h000, pad_oe[6:5]}, 14'h0000);
      @(posedge sys_clk);
      eeprom_present <= 1'b0;
      host_sel(4'h5, 2'h0, 1'b1);
      chk("gp_sel_oe", pad_oe & 14'h10E1, 14'h10E1);
      chk("gp_sel_out", pad_out & 14'h10E1, 14'h10E1);
   endtask

   task automatic t_wakeup;
      ext_oe[8] <= 1'b1;
      ext_val[8] <= 1'b0;
      look;
      chk("wake_on", {13'h0000, remote_wakeup}, 14'h0001);
      ext_val[8] <= 1'b1;
      look;
      chk("wake_off", {13'h0000, remote_wakeup}, 14'h0000);
   endtask

   task automatic summarize;
      $display("checks_done %0d err_count %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      {sys_clk, arst_n, param_valid, eeprom_present, host_sel_wr, host_gpio_wr} = '0;
      {interface_config_bit0, interface_config_bit1, host_i2c_gpio, uart_tx_busy} = '0;
      {i2c_scl_oe, i2c_sda_oe, tx_activity, rx_activity, usb_suspended} = '0;
      {charger_dedicated, param_sel_pin0, param_sel_pin7, param_sel_pin12} = '0;
      {param_drive, host_sel_val, host_sel_pin, host_gpio_out, host_gpio_oe} = '0;
      {ext_oe, ext_val} = '0;
      uart_txd = 1'b1;
      t_load;
      t_tx_active;
      t_charger;
      t_suspend;
      t_gpio;
      t_i2c;
      t_uart;
      t_wakeup;
      summarize;
   end

   initial begin
      #20000;
      err_count++;
      summarize;
   end
endmodule
